// file: rtl/tpa_core.sv
// Purpose: Phase-angle triac firing with soft start, retrigger and thermal fallback
// Assumes: Inputs synchronous to mclk_in; analog comparators and ADC are outside
// Notes: Counts run in ticks of one thousandth of a half period
`timescale 1ns/1ps
module tpa_core import tpa_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic high_supply_in,
	input wire logic zero_cross_input_in,
	input wire logic [3:0] speed_reading_in,
	input wire logic speed_valid_in,
	input wire logic overtemp_sense_in,
	input wire logic mode_feedback_in,
	input wire logic triac_on_in,
	input wire logic [4:0] soft_start_rate_in,
	input wire logic [1:0] pulse_width_select_in,
	input wire logic retrigger_enable_in,
	input wire logic [3:0] retrigger_mask_point_in,
	input wire logic [9:0] initial_delay_in,
	output logic triac_drive_out,
	output logic sense_switch_out,
	output logic two_wire_mode_out,
	output logic overtemp_active_out,
	output logic locked_out
);
	function automatic logic [5:0] width_ticks(input logic [1:0] sel);
		case (sel)
			2'b00: width_ticks = WIDTH_T00;
			2'b01: width_ticks = WIDTH_T01;
			2'b10: width_ticks = WIDTH_T10;
			default: width_ticks = WIDTH_T11;
		endcase
	endfunction : width_ticks

	logic zc_r, zc_nxt, seen_zc_r, seen_zc_nxt, zc_evt;
	logic [8:0] div_r, div_nxt, divcnt_r, divcnt_nxt, sar_r, sar_nxt;
	logic tick_100k_r, tick_100k_nxt, locked_r, locked_nxt;
	logic [10:0] pc_r, pc_nxt;
	logic [3:0] held_r, held_nxt, addr;
	logic [4:0] scaled;
	logic sense_r, sense_nxt, hot_r, hot_nxt, two_wire_r, two_wire_nxt;
	logic [9:0] fire_delay_target, ign_r, ign_nxt;
	logic [10:0] rcnt_r, rcnt_nxt, rstep;
	logic run_r, run_nxt;
	tpa_fire_t state_r, state_nxt;
	logic [5:0] wcnt_r, wcnt_nxt;
	logic second_r, second_nxt, drive_r, drive_nxt;
	logic [10:0] mask_ticks;

	assign zc_evt = zc_r ^ zero_cross_input_in;
	assign mask_ticks = 11'(retrigger_mask_point_in) << MASK_SHIFT;

	// Tick divider and frequency lock
	always_comb begin
		zc_nxt = zero_cross_input_in;
		seen_zc_nxt = seen_zc_r | zc_evt;
		div_nxt = div_r;
		sar_nxt = sar_r;
		locked_nxt = locked_r;
		tick_100k_nxt = 1'b0;
		divcnt_nxt = divcnt_r + 9'h001;
		if (divcnt_r >= div_r - 9'h001) begin
			divcnt_nxt = 9'h000;
			tick_100k_nxt = 1'b1;
		end
		pc_nxt = pc_r;
		if (tick_100k_r && pc_r != CNT_MAX)
			pc_nxt = pc_r + 11'h001;
		if (zc_evt) begin
			pc_nxt = 11'h000;
			if (seen_zc_r && sar_r != 9'h000) begin
				div_nxt = ((pc_r > TICKS_PER_HALF) ? div_r : (div_r & ~sar_r)) | (sar_r >> 1);
				sar_nxt = sar_r >> 1;
				locked_nxt = (sar_r == 9'h001);
			end else if (seen_zc_r) begin
				if (pc_r > TICKS_PER_HALF && div_r != 9'h1ff)
					div_nxt = div_r + 9'h001;
				else if (pc_r < TICKS_PER_HALF && div_r > 9'h002)
					div_nxt = div_r - 9'h001;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			zc_r <= 1'b0;
			seen_zc_r <= 1'b0;
			div_r <= SAR_FIRST;
			sar_r <= SAR_FIRST;
			locked_r <= 1'b0;
			divcnt_r <= 9'h000;
			tick_100k_r <= 1'b0;
			pc_r <= 11'h000;
		end else begin
			zc_r <= zc_nxt;
			seen_zc_r <= seen_zc_nxt;
			div_r <= div_nxt;
			sar_r <= sar_nxt;
			locked_r <= locked_nxt;
			divcnt_r <= divcnt_nxt;
			tick_100k_r <= tick_100k_nxt;
			pc_r <= pc_nxt;
		end
	end

	// Speed reading, sensing phases and table lookup
	always_comb begin
		held_nxt = held_r;
		// Debounce by more than one step
		if (speed_valid_in && ((speed_reading_in > held_r + 4'h1 && held_r != 4'hf) ||
			(held_r > speed_reading_in + 4'h1 && speed_reading_in != 4'hf)))
			held_nxt = speed_reading_in;
		sense_nxt = zc_evt ? ~sense_r : sense_r;
		hot_nxt = hot_r;
		two_wire_nxt = two_wire_r;
		if (sense_r)
			hot_nxt = overtemp_sense_in;
		else
			two_wire_nxt = mode_feedback_in;
		// Two-wire input spans half the range
		scaled = two_wire_r ? {held_r, 1'b0} : {1'b0, held_r};
		addr = (scaled > 5'h0f) ? 4'h0 : TOP_ADDR - scaled[3:0];
		fire_delay_target = hot_r ? POWER_ROM[0] : POWER_ROM[addr];
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			held_r <= 4'h0;
			sense_r <= 1'b0;
			hot_r <= 1'b0;
			two_wire_r <= 1'b0;
		end else begin
			held_r <= held_nxt;
			sense_r <= sense_nxt;
			hot_r <= hot_nxt;
			two_wire_r <= two_wire_nxt;
		end
	end

	// Soft-start ramp
	always_comb begin
		rstep = 11'({1'b0, soft_start_rate_in} + 6'h01) * RAMP_TICKS_PER_STEP;
		run_nxt = high_supply_in & locked_r;
		ign_nxt = ign_r;
		rcnt_nxt = rcnt_r;
		if (!run_r) begin
			ign_nxt = initial_delay_in;
			rcnt_nxt = 11'h000;
		end else if (tick_100k_r) begin
			rcnt_nxt = rcnt_r + 11'h001;
			if (rcnt_r >= rstep - 11'h001) begin
				rcnt_nxt = 11'h000;
				if (ign_r > fire_delay_target)
					ign_nxt = ign_r - 10'h001;
				else if (ign_r < fire_delay_target)
					ign_nxt = ign_r + 10'h001;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			run_r <= 1'b0;
			ign_r <= INITIAL_DELAY_RST;
			rcnt_r <= 11'h000;
		end else begin
			run_r <= run_nxt;
			ign_r <= ign_nxt;
			rcnt_r <= rcnt_nxt;
		end
	end

	// Firing sequencer
	always_comb begin
		state_nxt = state_r;
		wcnt_nxt = wcnt_r;
		second_nxt = second_r;
		case (state_r)
			ST_IDLE: begin
				if (tick_100k_r && run_r && pc_r == {1'b0, ign_r}) begin
					state_nxt = ST_PULSE;
					wcnt_nxt = width_ticks(pulse_width_select_in);
					second_nxt = 1'b0;
				end
			end
			ST_PULSE: begin
				if (tick_100k_r) begin
					wcnt_nxt = wcnt_r - 6'h01;
					if (wcnt_r == 6'h01) begin
						state_nxt = (!retrigger_enable_in && second_r) ? ST_DONE : ST_GAP;
						wcnt_nxt = GAP_TICKS;
					end
				end
			end
			ST_GAP: begin
				if (tick_100k_r) begin
					wcnt_nxt = wcnt_r - 6'h01;
					if (wcnt_r == 6'h01) begin
						wcnt_nxt = width_ticks(pulse_width_select_in);
						second_nxt = 1'b1;
						state_nxt = ST_DONE;
						if (retrigger_enable_in && !triac_on_in && pc_r < mask_ticks)
							state_nxt = ST_PULSE;
						else if (!retrigger_enable_in)
							state_nxt = ST_PULSE;
					end
				end
			end
			ST_DONE: state_nxt = ST_DONE;
			default: state_nxt = ST_DONE;
		endcase
		if (zc_evt)
			state_nxt = ST_IDLE;
		if (!high_supply_in)
			state_nxt = ST_DONE;
		drive_nxt = (state_nxt == ST_PULSE);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r <= ST_DONE;
			wcnt_r <= 6'h00;
			second_r <= 1'b0;
			drive_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			wcnt_r <= wcnt_nxt;
			second_r <= second_nxt;
			drive_r <= drive_nxt;
		end
	end

	assign triac_drive_out = drive_r;
	assign sense_switch_out = sense_r;
	assign two_wire_mode_out = two_wire_r;
	assign overtemp_active_out = hot_r;
	assign locked_out = locked_r;

	a_no_fire_low: assert property (@(posedge mclk_in) disable iff (rst_in)
		!high_supply_in |=> !triac_drive_out) else $error("drive while supply low");
	a_lock_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
		locked_out |=> locked_out) else $error("lock lost");
	a_zc_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
		zc_evt |=> pc_r == 11'h000) else $error("counter not cleared");
	a_fire_point: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(triac_drive_out) && $past(state_r == ST_IDLE) |-> $past(pc_r) == {1'b0, $past(ign_r)})
		else $error("fired off ignition point");
	a_debounce_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		speed_valid_in && ({1'b0, speed_reading_in} == {1'b0, held_r} ||
		{1'b0, speed_reading_in} == {1'b0, held_r} + 5'h01 ||
		{1'b0, speed_reading_in} + 5'h01 == {1'b0, held_r}) |=> $stable(held_r))
		else $error("jitter accepted");
	a_thermal_index: assert property (@(posedge mclk_in) disable iff (rst_in)
		overtemp_active_out |-> fire_delay_target == POWER_ROM[0]) else $error("no thermal fallback");
	a_ramp_initial: assert property (@(posedge mclk_in) disable iff (rst_in)
		!run_r |=> ign_r == $past(initial_delay_in)) else $error("ramp not at initial");
	a_ramp_step: assert property (@(posedge mclk_in) disable iff (rst_in)
		$past(run_r) && run_r && $changed(ign_r) |-> ign_r == $past(ign_r) + 10'h001 ||
		ign_r + 10'h001 == $past(ign_r)) else $error("ramp jumped");
	a_mask_point: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(triac_drive_out) && $past(state_r == ST_GAP) && $past(retrigger_enable_in) |->
		$past(pc_r) < $past(mask_ticks)) else $error("retrigger past mask");
	a_two_pulses: assert property (@(posedge mclk_in) disable iff (rst_in)
		state_r == ST_PULSE && second_r && !retrigger_enable_in && high_supply_in && !zc_evt
		&& tick_100k_r && wcnt_r == 6'h01 |=> state_r == ST_DONE) else $error("third pulse");
	c_fired: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(triac_drive_out));
	c_retrigger: cover property (@(posedge mclk_in) disable iff (rst_in)
		$rose(triac_drive_out) && $past(state_r == ST_GAP) && retrigger_enable_in);
	c_hot: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(overtemp_active_out));
	c_locked: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(locked_out));
endmodule : tpa_core

// file: inc/tpa_pkg.sv
// Purpose: Constants for the triac phase-angle soft-start core
// Assumes: 25 MHz clock, 50 Hz mains
// Notes: One tick is a thousandth of a mains half period
package tpa_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int MAINS_HZ = 50;
	localparam int TICK_HZ = 2 * MAINS_HZ * 1000;
	localparam logic [8:0] DIV_NOM = 9'(CLK_HZ / TICK_HZ);
	localparam logic [8:0] SAR_FIRST = 9'h100;
	localparam logic [10:0] TICKS_PER_HALF = 11'd1000;
	localparam logic [10:0] CNT_MAX = 11'h7ff;
	localparam int GAP_US = 20;
	localparam logic [5:0] GAP_TICKS = 6'((GAP_US * TICK_HZ + 999999) / 1000000);
	localparam logic [5:0] WIDTH_T00 = 6'd32;
	localparam logic [5:0] WIDTH_T01 = 6'd8;
	localparam logic [5:0] WIDTH_T10 = 6'd4;
	localparam logic [5:0] WIDTH_T11 = 6'd2;
	localparam logic [10:0] RAMP_TICKS_PER_STEP = 11'(800 / MAINS_HZ);
	localparam int MASK_SHIFT = 6;
	localparam logic [9:0] INITIAL_DELAY_RST = 10'd690;
	localparam logic [3:0] TOP_ADDR = 4'hf;
	typedef logic [9:0] tpa_rom_t [16];
	localparam tpa_rom_t POWER_ROM = '{
		10'd580, 10'd557, 10'd534, 10'd512, 10'd490, 10'd467, 10'd446, 10'd424,
		10'd401, 10'd377, 10'd352, 10'd325, 10'd295, 10'd263, 10'd221, 10'd102};
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PULSE = 4'b0010,
		ST_GAP = 4'b0100,
		ST_DONE = 4'b1000
	} tpa_fire_t;
endpackage : tpa_pkg

// file: verif/tpa_mains_model.sv
// Purpose: Mains zero-cross and triac gate model
// Assumes: Half period of HALF clock cycles
// Notes: Triac latches on only while responsive_in is high
`timescale 1ns/1ps
module tpa_mains_model #(parameter int HALF = 2000) (
	input wire logic mclk_in,
	input wire logic triac_drive_in,
	input wire logic responsive_in,
	output logic zero_cross_out = 1'b0,
	output logic triac_on_out = 1'b0
);
	int cyc_r = 0;
	int on_cnt_r = 0;
	always @(posedge mclk_in) begin
		if (cyc_r == HALF - 1) begin
			cyc_r <= 0;
			zero_cross_out <= ~zero_cross_out;
			triac_on_out <= 1'b0;
			on_cnt_r <= 0;
		end else begin
			cyc_r <= cyc_r + 1;
			on_cnt_r <= (triac_drive_in === 1'b1) ? on_cnt_r + 1 : 0;
			if (responsive_in && on_cnt_r == 3) begin
				triac_on_out <= 1'b1;
			end
		end
	end
endmodule : tpa_mains_model

// file: verif/triac_phase_angle_soft_start_tb.sv
// Purpose: Self-checking bench for the phase-angle core
// Assumes: Short half periods, so one tick is DIV cycles
// Notes: Pulse timing is measured from zero-cross edges
`timescale 1ns/1ps
module triac_phase_angle_soft_start_tb import tpa_pkg::*;;
	localparam int HALF = 2000;
	localparam int DIV = HALF / 1000;
	typedef struct {logic [1:0] sel; logic retrigger_enable; logic resp; logic [3:0] mask; int cnt; int wid;} tpa_row_t;
	tpa_row_t rows [5] = '{'{2'h0, 1'b0, 1'b1, 4'h0, 2, 32}, '{2'h1, 1'b0, 1'b0, 4'h0, 2, 8},
		'{2'h2, 1'b1, 1'b1, 4'hf, 1, 4}, '{2'h3, 1'b1, 1'b0, 4'h2, 7, 2}, '{2'h3, 1'b1, 1'b0, 4'h0, 1, 2}};
	logic clk = 1'b0, rst = 1'b1, supply = 1'b1, valid = 1'b0, hot = 1'b0, fb = 1'b0, resp = 1'b0;
	logic [3:0] speed = 4'h0, mask = 4'h0;
	logic [4:0] rate = 5'h00;
	logic s0 = 1'b0;
	logic [1:0] sel = 2'h0;
	logic retrigger_enable = 1'b0, zc, on, drive, drive_d = 1'b0, zc_d = 1'b0, sense, two_wire, ot, locked;
	logic [9:0] init_delay = POWER_ROM[TOP_ADDR];
	int fail_count = 0, total_checks = 0, cyc = 0, cnt = 0, rise = 0, wid = 0, pre = 0, r0;
	int l_cnt = 0, l_rise = 0, l_wid = 0;
	tpa_core u_dut (.mclk_in(clk), .rst_in(rst), .high_supply_in(supply), .zero_cross_input_in(zc),
		.speed_reading_in(speed), .speed_valid_in(valid), .overtemp_sense_in(hot),
		.mode_feedback_in(fb), .triac_on_in(on), .soft_start_rate_in(rate),
		.pulse_width_select_in(sel), .retrigger_enable_in(retrigger_enable), .retrigger_mask_point_in(mask),
		.initial_delay_in(init_delay), .triac_drive_out(drive), .sense_switch_out(sense),
		.two_wire_mode_out(two_wire), .overtemp_active_out(ot), .locked_out(locked));
	tpa_mains_model #(.HALF(HALF)) u_mains (.mclk_in(clk), .triac_drive_in(drive),
		.responsive_in(resp), .zero_cross_out(zc), .triac_on_out(on));
	initial begin
		forever #20 clk = ~clk;
	end
	// Per half period: pulse count, first rise and first width in ticks
	always @(posedge clk) begin
		zc_d <= zc;
		drive_d <= drive;
		if (drive === 1'b1 && locked !== 1'b1) pre <= pre + 1;
		if (zc !== zc_d) begin
			l_cnt <= cnt; l_rise <= rise / DIV; l_wid <= wid / DIV;
			cyc <= 0; cnt <= 0; rise <= 0; wid <= 0;
		end else begin
			cyc <= cyc + 1;
			if (drive === 1'b1 && drive_d !== 1'b1) cnt <= cnt + 1;
			if (drive === 1'b1 && drive_d !== 1'b1 && cnt == 0) rise <= cyc;
			if (drive === 1'b1 && (cnt == 0 || (cnt == 1 && drive_d === 1'b1))) wid <= wid + 1;
		end
	end
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_num(input int got, input int exp, input int tol);
		total_checks++;
		if (got < exp - tol || got > exp + tol) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_num
	task automatic halves(input int n);
		repeat (n) @(zc);
		repeat (3) @(negedge clk);
	endtask : halves
	task automatic set_speed(input logic [3:0] v);
		@(posedge clk);
		speed <= v;
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
	endtask : set_speed
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(negedge clk);
		chk_bit(drive, 1'b0);
		chk_bit(locked, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 30000 && locked !== 1'b1; i++) @(negedge clk);
		chk_bit(locked, 1'b1);
		chk_num(pre, 0, 0);
		$display("lock test done");
		halves(2);
		foreach (rows[i]) begin
			@(posedge clk);
			sel <= rows[i].sel; retrigger_enable <= rows[i].retrigger_enable; resp <= rows[i].resp; mask <= rows[i].mask;
			halves(2);
			chk_num(l_cnt, rows[i].cnt, 0);
			chk_num(l_wid, rows[i].wid, 0);
			chk_num(l_rise, POWER_ROM[TOP_ADDR], 2);
			$display("row %0d done", i);
		end
		@(posedge clk);
		supply <= 1'b0;
		halves(2);
		chk_num(l_cnt, 0, 0);
		@(posedge clk);
		supply <= 1'b1; sel <= 2'h1; retrigger_enable <= 1'b0;
		halves(2);
		chk_num(l_cnt, 2, 0);
		$display("supply test done");
		set_speed(4'h1);
		halves(2);
		chk_num(l_rise, POWER_ROM[TOP_ADDR], 2);
		set_speed(4'h3);
		halves(1);
		r0 = l_rise;
		halves(1);
		// Delay grows while the counter chases it: 1000 / (16 - 1) per half
		chk_num(l_rise - r0, 1000 / 15, 3);
		chk_bit(l_rise > POWER_ROM[TOP_ADDR] + 2 && l_rise < POWER_ROM[12], 1'b1);
		@(posedge clk);
		rate <= 5'h01;
		halves(1);
		r0 = l_rise;
		halves(1);
		// Step spacing doubles: 1000 / (32 - 1) per half
		chk_num(l_rise - r0, 1000 / 31, 3);
		$display("ramp test done");
		@(posedge clk);
		hot <= 1'b1; fb <= 1'b1;
		halves(3);
		chk_bit(ot, 1'b1);
		chk_bit(two_wire, 1'b1);
		s0 = sense;
		halves(1);
		chk_bit(sense, ~s0);
		@(posedge clk);
		hot <= 1'b0; fb <= 1'b0;
		halves(3);
		chk_bit(ot, 1'b0);
		chk_bit(two_wire, 1'b0);
		$display("sense test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(locked, 1'b0);
		chk_bit(sense, 1'b0);
		chk_bit(drive, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk_bit(drive, 1'b0);
		chk_bit(locked, 1'b0);
		$display("reset test done");
		wrap_up();
	end
endmodule : triac_phase_angle_soft_start_tb
